// >>> hw/tx_line_driver_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - bypass bit 0 in line control routes pulses through build-out shaping
// RL2 - bypass bit 1 skips shaping, sending square pulses
// RL3 - software enables shaping below 225 feet of cable, disables above
// RL4 - driver enabled only when register bit and enable pin are both high
// RL5 - register driver bit 0 tristates both line outputs
// RL6 - system holds the enable pin high for software control
// RL7 - protection switching writes the driver-enable register
// RL8 - monitor mode bit 0 senses activity on the external monitor pins
// RL9 - regular bipolar pulses keep the monitor alarm bit at zero
// RL10 - 128 silent bit periods set alarm, interrupt status and request low
// RL11 - one pulse during alarm clears it and raises a change interrupt
// RL12 - all-ones bit replaces framer data with unframed ones
// RL13 - monitor mode bit 1 senses the driver internally
// RL14 - unused control bits read zero and ignore writes
module tx_line_driver_control #(
  parameter int SILENCE_BITS = tx_line_pkg::SILENCE_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_line_driver_on,
  input wire logic i_bit_tick,
  input wire logic i_tx_pos,
  input wire logic i_tx_neg,
  input wire logic i_monitor_pos_in,
  input wire logic i_monitor_neg_in,
  output logic o_tx_line_pos_out,
  output logic o_tx_line_neg_out,
  output logic o_tx_line_oe,
  output logic o_build_out_bypass,
  output logic o_drive_monitor_alarm,
  output logic o_irq_n
);
  // ==========================================================
  // control registers
  logic [7:0] drv_reg, drv_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] int_reg, int_next;
  logic pos_reg, pos_next;
  logic neg_reg, neg_next;
  logic [7:0] rdata_reg, rdata_next;
  logic all_ones, int_mon;
  logic sense_pos, sense_neg;

  monitor_if mon_bus();

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  assign all_ones = ctrl_reg[tx_line_pkg::BIT_ALL_ONES];
  assign int_mon = ctrl_reg[tx_line_pkg::BIT_INT_MON];

  always_comb begin
    drv_next = drv_reg;
    ctrl_next = ctrl_reg;
    int_next = int_reg;
    rdata_next = rdata_reg;
    if (i_wr && hit(i_addr, tx_line_pkg::ADDR_DRIVER_ENABLE)) begin
      drv_next = i_wdata & tx_line_pkg::DRIVER_ENABLE_MASK; // RL14 RL7
    end
    if (i_wr && hit(i_addr, tx_line_pkg::ADDR_LINE_CTRL)) begin
      ctrl_next = i_wdata & tx_line_pkg::LINE_CTRL_MASK; // RL14
    end
    // reading the status register clears it; a new event in that cycle still wins
    if (i_rd && hit(i_addr, tx_line_pkg::ADDR_INT_STATUS)) begin
      int_next = 8'h00;
    end
    if (mon_bus.declare_evt || mon_bus.clear_evt) begin
      int_next[tx_line_pkg::BIT_MON_ALARM] = 1'b1; // RL10 RL11
    end
    if (i_rd) begin
      if (hit(i_addr, tx_line_pkg::ADDR_DRIVER_ENABLE)) begin
        rdata_next = drv_reg;
      end else if (hit(i_addr, tx_line_pkg::ADDR_LINE_CTRL)) begin
        rdata_next = ctrl_reg;
      end else if (hit(i_addr, tx_line_pkg::ADDR_INT_STATUS)) begin
        rdata_next = int_reg;
      end else if (hit(i_addr, tx_line_pkg::ADDR_ALARM_STATUS)) begin
        rdata_next = {7'h00, mon_bus.alarm}; // RL9
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // ==========================================================
  // outbound data path
  always_comb begin
    if (all_ones) begin
      // unframed all ones on a bipolar line: marks alternate polarity
      pos_next = i_bit_tick ? !pos_reg : pos_reg; // RL12
      neg_next = i_bit_tick ? pos_reg : neg_reg; // RL12
    end else begin
      pos_next = i_tx_pos; // RL12
      neg_next = i_tx_neg; // RL12
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drv_reg <= tx_line_pkg::DRIVER_ENABLE_RESET;
      ctrl_reg <= tx_line_pkg::LINE_CTRL_RESET;
      int_reg <= 8'h00;
      rdata_reg <= 8'h00;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      drv_reg <= drv_next;
      ctrl_reg <= ctrl_next;
      int_reg <= int_next;
      rdata_reg <= rdata_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_tx_line_pos_out = pos_reg;
  assign o_tx_line_neg_out = neg_reg;
  assign o_tx_line_oe = drv_reg[tx_line_pkg::BIT_DRIVER_ON] && i_line_driver_on; // RL4 RL5 RL6
  assign o_build_out_bypass = ctrl_reg[tx_line_pkg::BIT_BYPASS]; // RL1 RL2
  assign o_drive_monitor_alarm = mon_bus.alarm;
  assign o_irq_n = !int_reg[tx_line_pkg::BIT_MON_ALARM]; // RL10

  // ==========================================================
  // drive monitor sensing
  // internal mode watches our own driver, so a dead external path goes unseen
  assign sense_pos = int_mon ? (pos_reg && o_tx_line_oe) : i_monitor_pos_in; // RL8 RL13
  assign sense_neg = int_mon ? (neg_reg && o_tx_line_oe) : i_monitor_neg_in; // RL8 RL13
  assign mon_bus.bit_tick = i_bit_tick;
  assign mon_bus.pulse_seen = i_bit_tick && (sense_pos ^ sense_neg);

  drive_monitor #(.LIMIT(SILENCE_BITS)) u_monitor (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .m(mon_bus.mon)
  );

  // ==========================================================
  // checks
  // reference count of silent ticks, kept apart from the monitor's own counter
  // so that an off-by-one there cannot hide behind the same arithmetic
  int quiet_ticks_reg, quiet_ticks_next;

  always_comb begin
    quiet_ticks_next = quiet_ticks_reg;
    if (mon_bus.pulse_seen || mon_bus.alarm) begin
      quiet_ticks_next = 0;
    end else if (mon_bus.bit_tick) begin
      quiet_ticks_next = quiet_ticks_reg + 1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      quiet_ticks_reg <= 0;
    end else begin
      quiet_ticks_reg <= quiet_ticks_next;
    end
  end

  AST_OE_NEEDS_BOTH: assert property (@(posedge i_clk) disable iff (i_rst) // RL4
    o_tx_line_oe |-> drv_reg[0] && i_line_driver_on) else $error("driver on illegally");
  AST_OE_OFF: assert property (@(posedge i_clk) disable iff (i_rst) // RL5
    i_wr && hit(i_addr, tx_line_pkg::ADDR_DRIVER_ENABLE) && !i_wdata[0]
    |=> !o_tx_line_oe) else $error("driver not tristated");
  AST_BYPASS_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // RL1
    i_wr && hit(i_addr, tx_line_pkg::ADDR_LINE_CTRL)
    |=> o_build_out_bypass == $past(i_wdata[0])) else $error("bypass not stored");
  AST_BYPASS_SET: assert property (@(posedge i_clk) disable iff (i_rst) // RL2
    i_wr && hit(i_addr, tx_line_pkg::ADDR_LINE_CTRL) && i_wdata[0]
    |=> o_build_out_bypass) else $error("bypass not set");
  AST_PASS_DATA: assert property (@(posedge i_clk) disable iff (i_rst) // RL12
    !all_ones |=> o_tx_line_pos_out == $past(i_tx_pos)) else $error("data not passed");
  AST_ONES_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // RL12
    i_wr && hit(i_addr, tx_line_pkg::ADDR_LINE_CTRL)
    |=> all_ones == $past(i_wdata[tx_line_pkg::BIT_ALL_ONES]))
    else $error("all-ones bit not stored");
  AST_ONES_TOGGLE: assert property (@(posedge i_clk) disable iff (i_rst) // RL12
    all_ones && i_bit_tick |=> o_tx_line_pos_out != $past(o_tx_line_pos_out))
    else $error("all-ones marks do not alternate");
  AST_ONES_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // RL12
    all_ones && !i_bit_tick |=> $stable(o_tx_line_pos_out) && $stable(o_tx_line_neg_out))
    else $error("all-ones line moved between ticks");
  AST_UNUSED_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // RL14
    (ctrl_reg & ~tx_line_pkg::LINE_CTRL_MASK) == 8'h00 && drv_reg[7:1] == 7'h00)
    else $error("unused bits set");
  AST_EXT_SENSE: assert property (@(posedge i_clk) disable iff (i_rst) // RL8
    !int_mon && o_drive_monitor_alarm && i_bit_tick && (i_monitor_pos_in ^ i_monitor_neg_in)
    |=> !o_drive_monitor_alarm) else $error("external pulse not sensed");
  AST_INT_SENSE: assert property (@(posedge i_clk) disable iff (i_rst) // RL13
    int_mon && o_drive_monitor_alarm && i_bit_tick && o_tx_line_oe
    && (o_tx_line_pos_out ^ o_tx_line_neg_out) |=> !o_drive_monitor_alarm)
    else $error("internal pulse not sensed");
  AST_INT_NO_PINS: assert property (@(posedge i_clk) disable iff (i_rst) // RL13
    int_mon && !o_tx_line_oe |-> !mon_bus.pulse_seen) else $error("pins sensed internally");
  AST_IRQ_ON_DECLARE: assert property (@(posedge i_clk) disable iff (i_rst) // RL10
    mon_bus.declare_evt |=> !o_irq_n && o_drive_monitor_alarm) else $error("no irq");
  AST_DECLARE_AT_LIMIT: assert property (@(posedge i_clk) disable iff (i_rst) // RL10
    !mon_bus.alarm && mon_bus.bit_tick && !mon_bus.pulse_seen
    && quiet_ticks_reg == SILENCE_BITS - 1 |-> mon_bus.declare_evt)
    else $error("alarm late after silence");
  AST_NO_EARLY_DECLARE: assert property (@(posedge i_clk) disable iff (i_rst) // RL10
    mon_bus.declare_evt |-> quiet_ticks_reg == SILENCE_BITS - 1)
    else $error("alarm declared early");
  AST_STATUS_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst) // RL10
    i_rd && hit(i_addr, tx_line_pkg::ADDR_INT_STATUS) && !mon_bus.declare_evt
    && !mon_bus.clear_evt |=> o_irq_n) else $error("status read did not clear irq");
  AST_IRQ_ON_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst) // RL11
    mon_bus.clear_evt |=> !o_irq_n && !o_drive_monitor_alarm) else $error("no clear irq");
  AST_CLEAR_NEEDS_PULSE: assert property (@(posedge i_clk) disable iff (i_rst) // RL11
    mon_bus.clear_evt |-> mon_bus.alarm && mon_bus.pulse_seen)
    else $error("alarm cleared without pulse");
  AST_QUIET_OK: assert property (@(posedge i_clk) disable iff (i_rst) // RL9
    mon_bus.pulse_seen && !o_drive_monitor_alarm |=> !o_drive_monitor_alarm)
    else $error("alarm with pulses");
  AST_ALARM_READ: assert property (@(posedge i_clk) disable iff (i_rst) // RL9
    i_rd && hit(i_addr, tx_line_pkg::ADDR_ALARM_STATUS)
    |=> o_rdata == {7'h00, $past(o_drive_monitor_alarm)}) else $error("alarm read wrong");

  COV_DECLARE: cover property (@(posedge i_clk) disable iff (i_rst) mon_bus.declare_evt);
  COV_CLEAR: cover property (@(posedge i_clk) disable iff (i_rst) mon_bus.clear_evt);
  COV_ONES: cover property (@(posedge i_clk) disable iff (i_rst) all_ones && o_tx_line_oe);
  COV_INTMON: cover property (@(posedge i_clk) disable iff (i_rst) int_mon && o_tx_line_oe);
  COV_BYPASS: cover property (@(posedge i_clk) disable iff (i_rst)
    o_build_out_bypass && o_tx_line_oe);
endmodule

// >>> hw/tx_line_pkg.sv
package tx_line_pkg;
  // ==========================================================
  // register map (8-bit data on the device register port)
  localparam logic [15:0] ADDR_DRIVER_ENABLE = 16'h1300;
  localparam logic [15:0] ADDR_INT_STATUS = 16'h1302;
  localparam logic [15:0] ADDR_ALARM_STATUS = 16'h1303;
  localparam logic [15:0] ADDR_LINE_CTRL = 16'h1304;
  // ==========================================================
  // field positions
  localparam int BIT_DRIVER_ON = 0;
  localparam int BIT_BYPASS = 0;
  localparam int BIT_ALL_ONES = 2;
  localparam int BIT_INT_MON = 5;
  localparam int BIT_MON_ALARM = 0;
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] DRIVER_ENABLE_RESET = 8'h00;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [7:0] DRIVER_ENABLE_MASK = 8'h01;
  localparam logic [7:0] LINE_CTRL_MASK = 8'h25;
  // ==========================================================
  // bipolar silence limit, in line bit periods
  localparam int SILENCE_BITS = 128;
  localparam int SILENCE_W = 8;
endpackage

// >>> hw/monitor_if.sv
`timescale 1ns/1ps
interface monitor_if;
  logic bit_tick;
  logic pulse_seen;
  logic alarm;
  logic declare_evt;
  logic clear_evt;
  modport ctrl(output bit_tick, output pulse_seen, input alarm, input declare_evt,
    input clear_evt);
  modport mon(input bit_tick, input pulse_seen, output alarm, output declare_evt,
    output clear_evt);
endinterface

// >>> hw/drive_monitor.sv
`timescale 1ns/1ps
module drive_monitor #(
  parameter int LIMIT = tx_line_pkg::SILENCE_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  monitor_if.mon m
);
  // ==========================================================
  // silence counter and alarm state
  typedef enum logic [0:0] {ST_OK = 1'b0, ST_ALARM = 1'b1} mon_state_type;
  mon_state_type state_reg, state_next;
  localparam int CNT_W = tx_line_pkg::SILENCE_W;
  logic [CNT_W-1:0] count_reg, count_next;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    m.declare_evt = 1'b0;
    m.clear_evt = 1'b0;
    case (state_reg)
      ST_OK: begin
        if (m.pulse_seen) begin
          count_next = '0; // RL9
        end else if (m.bit_tick) begin
          if (count_reg == LAST) begin
            state_next = ST_ALARM; // RL10
            m.declare_evt = 1'b1;
            count_next = '0;
          end else begin
            count_next = count_reg + 1'b1;
          end
        end
      end
      ST_ALARM: begin
        if (m.pulse_seen) begin
          state_next = ST_OK; // RL11
          m.clear_evt = 1'b1;
          count_next = '0;
        end
      end
      default: begin
        state_next = ST_OK;
        count_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_OK;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign m.alarm = (state_reg == ST_ALARM);

  // ==========================================================
  // checks
  AST_CLEAR_ON_PULSE: assert property (@(posedge i_clk) disable iff (i_rst) // RL11
    m.alarm && m.pulse_seen |=> !m.alarm) else $error("alarm not cleared by pulse");
  AST_PULSE_KEEPS_OK: assert property (@(posedge i_clk) disable iff (i_rst) // RL9
    !m.alarm && m.pulse_seen |=> !m.alarm) else $error("alarm despite pulse");
endmodule

// >>> verification/line_model.sv
`timescale 1ns/1ps
// ==========================================================
// coaxial line with the monitor taps wired back to the line
module line_model (
  input wire logic i_pos,
  input wire logic i_neg,
  input wire logic i_oe,
  input wire logic i_cut,
  output logic o_mon_pos,
  output logic o_mon_neg
);
  // the line is terminated to ground, so a tristated driver or a broken
  // cable reads as no mark at all rather than the last value driven
  assign o_mon_pos = i_oe & ~i_cut & i_pos;
  assign o_mon_neg = i_oe & ~i_cut & i_neg;
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst, i_wr, i_rd, i_pin, i_tick, i_tx_pos, i_tx_neg, cut, p;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, junk;
  logic o_pos, o_neg, o_oe, o_byp, o_alarm, o_irq_n, mon_pos, mon_neg;
  int fail_count, cmp_count;
  // short silence limit keeps the alarm scenarios quick
  localparam int SB = 8;
  // ==========================================================
  // clock and line bit tick
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial i_tick = 1'b0;
  always @(posedge i_clk) i_tick <= #1 ~i_tick;
  // ==========================================================
  // design and line
  tx_line_driver_control #(.SILENCE_BITS(SB)) DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_line_driver_on(i_pin), .i_bit_tick(i_tick), .i_tx_pos(i_tx_pos),
    .i_tx_neg(i_tx_neg), .i_monitor_pos_in(mon_pos), .i_monitor_neg_in(mon_neg),
    .o_tx_line_pos_out(o_pos), .o_tx_line_neg_out(o_neg), .o_tx_line_oe(o_oe),
    .o_build_out_bypass(o_byp), .o_drive_monitor_alarm(o_alarm), .o_irq_n(o_irq_n));
  line_model LINE (.i_pos(o_pos), .i_neg(o_neg), .i_oe(o_oe), .i_cut(cut),
    .o_mon_pos(mon_pos), .o_mon_neg(mon_neg));
  // ==========================================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(posedge i_clk);
    #1 i_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1 i_addr = a;
    i_rd = 1'b1;
    @(posedge i_clk);
    #1 i_rd = 1'b0;
    d = o_rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // bounded wait: gives up after 200 cycles and lets the compare report it
  task automatic wait_alarm(input logic v);
    for (int k = 0; k < 200 && o_alarm !== v; k++) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    i_rst = 1'b1;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_pin = 1'b1;
    i_tx_pos = 1'b0;
    i_tx_neg = 1'b0;
    cut = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge i_clk);
    #1 i_rst = 1'b0;
    rdc(tx_line_pkg::ADDR_DRIVER_ENABLE, 8'h00);
    rdc(tx_line_pkg::ADDR_LINE_CTRL, 8'h00);
    chk({7'h00, o_oe}, 8'h00);
    wr(tx_line_pkg::ADDR_DRIVER_ENABLE, 8'hFF);
    rdc(tx_line_pkg::ADDR_DRIVER_ENABLE, 8'h01);
    wr(tx_line_pkg::ADDR_LINE_CTRL, 8'hFF);
    rdc(tx_line_pkg::ADDR_LINE_CTRL, 8'h25);
    chk({7'h00, o_byp}, 8'h01);
    wr(tx_line_pkg::ADDR_LINE_CTRL, 8'h00);
    chk({7'h00, o_byp}, 8'h00);
    rdc(16'h1310, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(tx_line_pkg::ADDR_DRIVER_ENABLE, {7'h00, m[0]});
      i_pin = m[1];
      #1 chk({7'h00, o_oe}, {7'h00, m[0] & m[1]});
    end
    i_tx_pos = 1'b1;
    cyc(2);
    chk({6'h00, o_pos, o_neg}, 8'h02);
    i_tx_pos = 1'b0;
    i_tx_neg = 1'b1;
    cyc(2);
    chk({6'h00, o_pos, o_neg}, 8'h01);
    i_tx_neg = 1'b0;
    wr(tx_line_pkg::ADDR_LINE_CTRL, 8'h04);
    cyc(4);
    p = o_pos;
    chk({7'h00, o_pos ^ o_neg}, 8'h01);
    cyc(2);
    chk({7'h00, o_pos}, {7'h00, ~p});
    cyc(40);
    chk({7'h00, o_alarm}, 8'h00);
    wr(tx_line_pkg::ADDR_ALARM_STATUS, 8'hFF);
    rdc(tx_line_pkg::ADDR_ALARM_STATUS, 8'h00);
    rd(tx_line_pkg::ADDR_INT_STATUS, junk);
    chk({7'h00, o_irq_n}, 8'h01);
    // external mode must notice the cut even though the driver still pulses
    cut = 1'b1;
    // ticks come every other cycle, so the last silent tick lands near 2*SB cycles
    cyc(2 * SB - 2);
    chk({7'h00, o_alarm}, 8'h00);
    cyc(4);
    chk({7'h00, o_alarm}, 8'h01);
    chk({7'h00, o_irq_n}, 8'h00);
    rdc(tx_line_pkg::ADDR_ALARM_STATUS, 8'h01);
    rdc(tx_line_pkg::ADDR_INT_STATUS, 8'h01);
    chk({7'h00, o_irq_n}, 8'h01);
    cut = 1'b0;
    wait_alarm(1'b0);
    chk({7'h00, o_alarm}, 8'h00);
    chk({7'h00, o_irq_n}, 8'h00);
    rdc(tx_line_pkg::ADDR_INT_STATUS, 8'h01);
    wr(tx_line_pkg::ADDR_LINE_CTRL, 8'h24);
    cut = 1'b1;
    cyc(40);
    chk({7'h00, o_alarm}, 8'h00);
    wr(tx_line_pkg::ADDR_DRIVER_ENABLE, 8'h00);
    chk({7'h00, o_oe}, 8'h00);
    wait_alarm(1'b1);
    chk({7'h00, o_alarm}, 8'h01);
    // a second reset in mid-run must bring every control back to its idle value
    wr(tx_line_pkg::ADDR_LINE_CTRL, 8'h01);
    wr(tx_line_pkg::ADDR_DRIVER_ENABLE, 8'h01);
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    chk({4'h0, o_oe, o_byp, o_alarm, o_irq_n}, 8'h01);
    rdc(tx_line_pkg::ADDR_LINE_CTRL, 8'h00);
    rdc(tx_line_pkg::ADDR_INT_STATUS, 8'h00);
    summarize();
  end
  initial begin
    #50000;
    fail_count++;
    summarize();
  end
endmodule
